//--- hw/fos_pkg.sv
// shared constants and types of the flash status link, device end and host end
`default_nettype none
package fos_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int ADDR_W        = 4;
    localparam int DATA_W        = 8;
    localparam int TMR_W         = 12;
    localparam int ERASE_WIN_US  = 50;
    localparam int PROG_TIME_NS  = 2000;
    localparam int ERASE_TIME_NS = 20000;
    localparam int LIMIT_TIME_NS = 10000;
    localparam logic [TMR_W-1:0] ERASE_WIN_CYC = TMR_W'((ERASE_WIN_US * 1000) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] PROG_CYC      = TMR_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] ERASE_CYC     = TMR_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] LIMIT_CYC     = TMR_W'((LIMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [127:0]     MEM_RESET     = {16{8'hff}};
    localparam logic [7:0] CMD_PROG    = 8'ha0;
    localparam logic [7:0] CMD_SERASE  = 8'h30;
    localparam logic [7:0] CMD_CERASE  = 8'h10;
    localparam logic [7:0] CMD_RESET   = 8'hf0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME  = 8'h3a;
    localparam int BIT_POLL    = 7;
    localparam int BIT_TOGGLE  = 6;
    localparam int BIT_LIMIT   = 5;
    localparam int BIT_WINDOW  = 3;
    localparam int BIT_STOGGLE = 2;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RESULT = 8'h10;
    localparam logic [2:0] OP_PROG   = 3'h1;
    localparam logic [2:0] OP_SERASE = 3'h2;
    localparam logic [2:0] OP_CERASE = 3'h3;
    localparam logic [2:0] OP_POLL   = 3'h4;
    localparam logic [2:0] OP_RESET  = 3'h5;
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_REJECT  = 4;
    localparam logic [11:0] RETRY_MAX = 12'h7d0;
    typedef enum logic [2:0] {
        DS_READ    = 3'b000,
        DS_PWAIT   = 3'b001,
        DS_PROGRAM = 3'b010,
        DS_WINDOW  = 3'b011,
        DS_ERASE   = 3'b100,
        DS_SUSPEND = 3'b101,
        DS_FAIL    = 3'b110
    } fos_dev_state_t;
    typedef enum logic [3:0] {
        HS_IDLE  = 4'b0000,
        HS_WR1   = 4'b0001,
        HS_WR2   = 4'b0010,
        HS_PRE   = 4'b0011,
        HS_POST  = 4'b0100,
        HS_RD1   = 4'b0101,
        HS_RD2   = 4'b0110,
        HS_ARRAY = 4'b0111,
        HS_RST   = 4'b1000
    } fos_host_state_t;
endpackage : fos_pkg
`default_nettype wire

//--- hw/fos_link_if.sv
// parallel read/write strobe link between flash device and status-polling host
`timescale 1ns/1ns
`default_nettype none
interface fos_link_if (
    input wire logic pclk
);
    import fos_pkg::*;
    logic              rd_stb;
    logic              wr_stb;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              ack;
    logic [DATA_W-1:0] rdata;
    logic              ready_busy_out_o;
    logic              ready_busy_out_oe_n;
    logic              ready_busy_level;
    // open drain with pull-up
    assign ready_busy_level = ready_busy_out_oe_n ? 1'b1 : ready_busy_out_o;
    modport device (
        input  rd_stb,
        input  wr_stb,
        input  addr,
        input  wdata,
        output ack,
        output rdata,
        output ready_busy_out_o,
        output ready_busy_out_oe_n
    );
    modport host (
        output rd_stb,
        output wr_stb,
        output addr,
        output wdata,
        input  ack,
        input  rdata,
        input  ready_busy_level
    );
endinterface : fos_link_if
`default_nettype wire

//--- hw/fos_device.sv
// flash device end: array, embedded program/erase sequencer and status byte
`timescale 1ns/1ns
`default_nettype none
module fos_device (
    input  wire logic   pclk,
    input  wire logic   presetn,
    fos_link_if.device  link,
    output logic        dev_busy,
    output logic        dev_failed
);
    import fos_pkg::*;

    typedef struct packed {
        fos_dev_state_t         state;
        logic [15:0][7:0]       mem;
        logic [3:0]             sel;
        logic [TMR_W-1:0]       tmr;
        logic [ADDR_W-1:0]      paddr;
        logic [DATA_W-1:0]      pdata;
        logic                   bad;
        logic                   is_erase;
        logic                   limit;
        logic                   tog;
        logic                   stog;
        logic                   ack;
        logic [DATA_W-1:0]      rdata;
    } fos_dev_s_t;

    fos_dev_s_t s_reg;
    fos_dev_s_t s_next;

    logic [DATA_W-1:0] status_byte;
    logic [3:0]        addr_sector;
    logic              in_sel;
    logic              busy_state;

    assign addr_sector = 4'h1 << link.addr[ADDR_W-1:2];
    // sector toggle and poll bits only make sense inside a selected sector
    assign in_sel      = (s_reg.sel & addr_sector) != 4'h0;

    always_comb
    begin
        status_byte = 8'h00;
        status_byte[BIT_POLL]    = s_reg.is_erase ? 1'b0 : ~s_reg.pdata[BIT_POLL];
        status_byte[BIT_TOGGLE]  = s_reg.tog;
        status_byte[BIT_LIMIT]   = s_reg.limit;
        status_byte[BIT_WINDOW]  = (s_reg.state == DS_ERASE) || (s_reg.state == DS_SUSPEND);
        status_byte[BIT_STOGGLE] = s_reg.stog;
    end

    always_comb
    begin
        s_next     = s_reg;
        s_next.ack = 1'b0;

        // embedded timer; suspended erase keeps its remaining count
        if ((s_reg.tmr != '0) && (s_reg.state != DS_SUSPEND))
        begin
            s_next.tmr = s_reg.tmr - 12'h001;
            if (s_reg.tmr == 12'h001)
            begin
                case (s_reg.state)
                    DS_PROGRAM:
                    begin
                        if (s_reg.bad)
                        begin
                            s_next.state = DS_FAIL;
                            s_next.limit = 1'b1;
                        end
                        else
                        begin
                            s_next.mem[s_reg.paddr] = s_reg.mem[s_reg.paddr] & s_reg.pdata;
                            s_next.state = DS_READ;
                        end
                    end
                    DS_WINDOW:
                    begin
                        s_next.state = DS_ERASE;
                        s_next.tmr   = ERASE_CYC;
                    end
                    DS_ERASE:
                    begin
                        for (int i = 0; i < 16; i++)
                        begin
                            if (s_reg.sel[i / 4])
                            begin
                                s_next.mem[i] = 8'hff;
                            end
                        end
                        s_next.state = DS_READ;
                    end
                    default:
                    begin
                        s_next.state = s_reg.state;
                    end
                endcase
            end
        end

        if (link.rd_stb)
        begin
            s_next.ack = 1'b1;
            case (s_reg.state)
                DS_READ,
                DS_PWAIT:
                begin
                    s_next.rdata = s_reg.mem[link.addr];
                end
                DS_SUSPEND:
                begin
                    // toggle bit stands still while suspended; only selected sectors show status
                    if (in_sel)
                    begin
                        s_next.rdata = status_byte;
                        s_next.stog  = ~s_reg.stog;
                    end
                    else
                    begin
                        s_next.rdata = s_reg.mem[link.addr];
                    end
                end
                default:
                begin
                    s_next.rdata = status_byte;
                    s_next.tog   = ~s_reg.tog;
                    if (s_reg.is_erase && in_sel)
                    begin
                        s_next.stog = ~s_reg.stog;
                    end
                end
            endcase
        end

        if (link.wr_stb)
        begin
            s_next.ack = 1'b1;
            case (s_reg.state)
                DS_READ:
                begin
                    if (link.wdata == CMD_PROG)
                    begin
                        s_next.state = DS_PWAIT;
                    end
                    else if (link.wdata == CMD_SERASE)
                    begin
                        s_next.state    = DS_WINDOW;
                        s_next.sel      = addr_sector;
                        s_next.tmr      = ERASE_WIN_CYC;
                        s_next.is_erase = 1'b1;
                    end
                    else if (link.wdata == CMD_CERASE)
                    begin
                        // chip erase starts at once, no acceptance window
                        s_next.state    = DS_ERASE;
                        s_next.sel      = 4'hf;
                        s_next.tmr      = ERASE_CYC;
                        s_next.is_erase = 1'b1;
                    end
                end
                DS_PWAIT:
                begin
                    s_next.paddr    = link.addr;
                    s_next.pdata    = link.wdata;
                    s_next.is_erase = 1'b0;
                    s_next.state    = DS_PROGRAM;
                    // a 1 over a stored 0 cannot be programmed; pulses run until the limit
                    s_next.bad = ((~s_reg.mem[link.addr]) & link.wdata) != 8'h00;
                    s_next.tmr = s_next.bad ? LIMIT_CYC : PROG_CYC;
                end
                DS_WINDOW:
                begin
                    if (link.wdata == CMD_SERASE)
                    begin
                        s_next.state = DS_WINDOW;
                        s_next.sel   = s_reg.sel | addr_sector;
                        s_next.tmr   = ERASE_WIN_CYC;
                    end
                end
                DS_ERASE:
                begin
                    // erase about to finish in this cycle is not suspended
                    if ((link.wdata == CMD_SUSPEND) && (s_reg.tmr != 12'h001))
                    begin
                        s_next.state = DS_SUSPEND;
                    end
                end
                DS_SUSPEND:
                begin
                    if (link.wdata == CMD_RESUME)
                    begin
                        s_next.state = DS_ERASE;
                    end
                end
                DS_FAIL:
                begin
                    if (link.wdata == CMD_RESET)
                    begin
                        s_next.state    = DS_READ;
                        s_next.limit    = 1'b0;
                        s_next.tmr      = '0;
                        s_next.sel      = 4'h0;
                        s_next.is_erase = 1'b0;
                    end
                end
                default:
                begin
                    s_next.state = s_next.state;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '{state: DS_READ, mem: MEM_RESET, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign busy_state = (s_reg.state == DS_PROGRAM) || (s_reg.state == DS_WINDOW) ||
                        (s_reg.state == DS_ERASE) || (s_reg.state == DS_FAIL);

    assign link.ack                 = s_reg.ack;
    assign link.rdata               = s_reg.rdata;
    assign link.ready_busy_out_o    = 1'b0;
    assign link.ready_busy_out_oe_n = ~busy_state;
    assign dev_busy                 = busy_state;
    assign dev_failed               = s_reg.limit;
endmodule : fos_device
`default_nettype wire

//--- hw/fos_host.sv
// status-polling host: apb register slave that drives program, erase and toggle polling
`timescale 1ns/1ns
`default_nettype none
module fos_host (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    fos_link_if.host          link
);
    import fos_pkg::*;

    typedef struct packed {
        fos_host_state_t    state;
        logic [2:0]         op;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
        logic [DATA_W-1:0]  first;
        logic [DATA_W-1:0]  result;
        logic [11:0]        retry;
        logic               recheck;
        logic               pend;
        logic               done;
        logic               fail;
        logic               timeout;
        logic               reject;
        logic               rd_stb;
        logic               wr_stb;
        logic [DATA_W-1:0]  lwdata;
        logic [31:0]        prdata;
    } fos_host_s_t;

    fos_host_s_t s_reg;
    fos_host_s_t s_next;

    logic        mapped;
    logic [31:0] rmux;

    assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_DATA) ||
                    (paddr == REG_STATUS) || (paddr == REG_RESULT);

    always_comb
    begin
        rmux = 32'h0000_0000;
        case (paddr)
            REG_CTRL:   rmux = {29'h0, s_reg.op};
            REG_ADDR:   rmux = {28'h0, s_reg.addr};
            REG_DATA:   rmux = {24'h0, s_reg.data};
            REG_STATUS: rmux = {27'h0, s_reg.reject, s_reg.timeout, s_reg.fail, s_reg.done, s_reg.state != HS_IDLE};
            REG_RESULT: rmux = {24'h0, s_reg.result};
            default:    rmux = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        s_next        = s_reg;
        s_next.rd_stb = 1'b0;
        s_next.wr_stb = 1'b0;
        if (psel && !penable)
        begin
            s_next.prdata = rmux;
        end
        if (psel && penable && pwrite && (s_reg.state == HS_IDLE))
        begin
            if (paddr == REG_ADDR)
            begin
                s_next.addr = pwdata[ADDR_W-1:0];
            end
            if (paddr == REG_DATA)
            begin
                s_next.data = pwdata[DATA_W-1:0];
            end
            if (paddr == REG_CTRL)
            begin
                s_next.op      = pwdata[2:0];
                s_next.done    = 1'b0;
                s_next.fail    = 1'b0;
                s_next.timeout = 1'b0;
                s_next.reject  = 1'b0;
                s_next.retry   = 12'h000;
                s_next.recheck = 1'b0;
                case (pwdata[2:0])
                    OP_PROG,
                    OP_CERASE: s_next.state = HS_WR1;
                    OP_SERASE: s_next.state = HS_PRE;
                    OP_POLL:   s_next.state = HS_RD1;
                    OP_RESET:  s_next.state = HS_RST;
                    default:   s_next.state = HS_IDLE;
                endcase
            end
        end

        if ((s_reg.state != HS_IDLE) && !s_reg.pend)
        begin
            s_next.pend = 1'b1;
            case (s_reg.state)
                HS_WR1:
                begin
                    s_next.wr_stb = 1'b1;
                    s_next.lwdata = (s_reg.op == OP_PROG) ? CMD_PROG :
                                    (s_reg.op == OP_SERASE) ? CMD_SERASE : CMD_CERASE;
                end
                HS_WR2:
                begin
                    s_next.wr_stb = 1'b1;
                    s_next.lwdata = s_reg.data;
                end
                HS_RST:
                begin
                    s_next.wr_stb = 1'b1;
                    s_next.lwdata = CMD_RESET;
                end
                default:
                begin
                    s_next.rd_stb = 1'b1;
                end
            endcase
        end

        if (s_reg.pend && link.ack)
        begin
            s_next.pend = 1'b0;
            case (s_reg.state)
                HS_WR1:
                begin
                    s_next.state = (s_reg.op == OP_PROG) ? HS_WR2 :
                                   (s_reg.op == OP_SERASE) ? HS_POST : HS_IDLE;
                    s_next.done  = (s_reg.op == OP_CERASE);
                end
                HS_PRE:
                begin
                    s_next.first = link.rdata;
                    s_next.state = HS_WR1;
                end
                HS_POST:
                begin
                    s_next.reject = link.rdata[BIT_WINDOW];
                    s_next.done   = 1'b1;
                    s_next.state  = HS_IDLE;
                end
                HS_RD1:
                begin
                    s_next.first = link.rdata;
                    s_next.state = HS_RD2;
                end
                HS_RD2:
                begin
                    if (s_reg.first[BIT_TOGGLE] == link.rdata[BIT_TOGGLE])
                    begin
                        s_next.state = HS_ARRAY;
                    end
                    else if (s_reg.recheck)
                    begin
                        s_next.fail  = 1'b1;
                        s_next.state = HS_RST;
                    end
                    else if (link.rdata[BIT_LIMIT])
                    begin
                        s_next.recheck = 1'b1;
                        s_next.state   = HS_RD1;
                    end
                    else if (s_reg.retry == RETRY_MAX)
                    begin
                        s_next.timeout = 1'b1;
                        s_next.state   = HS_IDLE;
                    end
                    else
                    begin
                        // a fresh pair each time, never one read against a stale value
                        s_next.retry = s_reg.retry + 12'h001;
                        s_next.state = HS_RD1;
                    end
                end
                HS_ARRAY:
                begin
                    s_next.result = link.rdata;
                    s_next.done   = 1'b1;
                    s_next.state  = HS_IDLE;
                end
                default:
                begin
                    s_next.done  = 1'b1;
                    s_next.state = HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_reg <= '{state: HS_IDLE, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign prdata      = s_reg.prdata;
    assign pready      = penable;
    assign pslverr     = psel && penable && !mapped;
    assign link.rd_stb = s_reg.rd_stb;
    assign link.wr_stb = s_reg.wr_stb;
    // polling reads go to the programmed or erased address so that status bits are valid
    assign link.addr   = s_reg.addr;
    assign link.wdata  = s_reg.lwdata;
endmodule : fos_host
`default_nettype wire

//--- verif/fos_link_sva.sv
// assertions on the link between the flash device end and the polling host end
`timescale 1ns/1ns
`default_nettype none
module fos_link_sva
    import fos_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              rd_stb,
    input wire logic              wr_stb,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              ack,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              ready_busy_level,
    input wire logic              dev_busy,
    input wire logic              dev_failed
);
    logic busy_rd;
    logic tog_ok;
    logic tog_val;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a write or an idle spell breaks the read pair, so the toggle memory restarts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_rd <= 1'b0;
            tog_ok  <= 1'b0;
            tog_val <= 1'b0;
        end
        else
        begin
            busy_rd <= rd_stb && dev_busy;
            if (wr_stb || !dev_busy)
                tog_ok <= 1'b0;
            else if (ack && busy_rd)
            begin
                tog_ok  <= 1'b1;
                tog_val <= rdata[BIT_TOGGLE];
            end
        end
    end
    a_ack_after_stb: assert property ((rd_stb || wr_stb) |=> ack) else $error("strobe without ack");
    a_ack_cause: assert property (ack |-> $past(rd_stb || wr_stb)) else $error("ack without strobe");
    a_host_spacing: assert property ((rd_stb || wr_stb) |=> !(rd_stb || wr_stb))
        else $error("strobes too close");
    a_toggle_flip: assert property ((ack && busy_rd && dev_busy && tog_ok) |-> rdata[BIT_TOGGLE] != tog_val)
        else $error("toggle bit did not flip while busy");
    a_fail_busy: assert property (dev_failed |-> dev_busy && !ready_busy_level)
        else $error("failed device not busy");
    a_limit_flag: assert property ((ack && busy_rd && $past(dev_failed)) |-> rdata[BIT_LIMIT])
        else $error("limit flag clear in failure");
    a_limit_clear: assert property ((wr_stb && wdata == CMD_RESET && dev_failed) |-> ##[1:2] !dev_failed)
        else $error("reset command left failure");
    a_rdata_hold: assert property (!(ack && $past(rd_stb)) |-> $stable(rdata))
        else $error("read data moved without read");
endmodule : fos_link_sva
`default_nettype wire

//--- verif/tb.sv
// bench: apb stimulus into the host end, which polls the device end over the link
`timescale 1ns/1ns
`default_nettype none
module tb;
    import fos_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        dev_busy;
    logic        dev_failed;
    logic [31:0] rd;
    logic [31:0] st;
    logic        err;
    int          bad_count;
    int          n_checks;
    int          cyc;
    int          t0;
    fos_link_if link (.pclk(pclk));
    fos_device u_fos_device (.pclk(pclk), .presetn(presetn), .link(link.device), .dev_busy(dev_busy),
        .dev_failed(dev_failed));
    fos_host u_fos_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
    fos_link_sva u_fos_link_sva (.pclk(pclk), .presetn(presetn), .rd_stb(link.rd_stb), .wr_stb(link.wr_stb),
        .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .ready_busy_level(link.ready_busy_level),
        .dev_busy(dev_busy), .dev_failed(dev_failed));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // wait states are bounded so a dead slave ends the run instead of hanging it
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 16);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            bad_count++;
            summarize();
        end
    endtask : apb
    task op(input logic [2:0] o);
        int i;
        apb(1'b1, REG_CTRL, {29'h0, o});
        for (i = 0; i < 4000; i++)
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[ST_BUSY] === 1'b0 && rd[ST_DONE] === 1'b1)
                break;
        end
        st = rd;
        if (i >= 4000)
        begin
            bad_count++;
            summarize();
        end
    endtask : op
    task prog(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, REG_ADDR, {24'h0, a});
        apb(1'b1, REG_DATA, {24'h0, d});
        op(OP_PROG);
    endtask : prog
    task poll_at(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b1, REG_ADDR, {24'h0, a});
        op(OP_POLL);
        check("poll fail", {31'h0, st[ST_FAIL]}, 32'h0);
        apb(1'b0, REG_RESULT, 32'h0);
        check("result", rd, {24'h0, exp});
    endtask : poll_at
    task serase(input logic [7:0] a, input logic exp);
        apb(1'b1, REG_ADDR, {24'h0, a});
        op(OP_SERASE);
        check("reject", {31'h0, st[ST_REJECT]}, {31'h0, exp});
    endtask : serase
    initial
    begin
        cyc = 0;
        bad_count = 0;
        n_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        prog(8'h01, 8'h5a);
        poll_at(8'h01, 8'h5a);
        prog(8'h0c, 8'h3c);
        poll_at(8'h0c, 8'h3c);
        $display("test program done");
        // ff over 5a asks to raise stored zeros, which only erase may do
        prog(8'h01, 8'hff);
        op(OP_POLL);
        check("limit fail", {31'h0, st[ST_FAIL]}, 32'h1);
        check("dev_failed", {31'h0, dev_failed}, 32'h0);
        // second failure is cleared by the plain reset operation, without a poll first
        prog(8'h01, 8'hff);
        repeat (300) @(posedge pclk);
        check("limit flag set", {31'h0, dev_failed}, 32'h1);
        op(OP_RESET);
        check("reset op fail", {31'h0, st[ST_FAIL]}, 32'h0);
        check("reset op clears", {31'h0, dev_failed}, 32'h0);
        poll_at(8'h01, 8'h5a);
        $display("test limit done");
        serase(8'h01, 1'b0);
        repeat (1000) @(posedge pclk);
        serase(8'h04, 1'b0);
        // beyond one window from the first command, so only a restarted timer accepts it
        repeat (1000) @(posedge pclk);
        serase(8'h08, 1'b0);
        repeat (1300) @(posedge pclk);
        serase(8'h0c, 1'b1);
        poll_at(8'h01, 8'hff);
        poll_at(8'h0c, 8'h3c);
        $display("test sector erase done");
        t0 = cyc;
        op(OP_CERASE);
        poll_at(8'h0c, 8'hff);
        check("chip erase short", {31'h0, (cyc - t0) < int'(ERASE_WIN_CYC)}, 32'h1);
        $display("test chip erase done");
        apb(1'b0, 8'h20, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        $display("test unmapped done");
        summarize();
    end
endmodule : tb
`default_nettype wire
